// ### rtl/lcc_pkg.sv
// constants for the lane conditioning configuration register bank
package lcc_pkg;
  localparam logic [7:0] OFS_SOFT_RESET     = 8'h00;
  localparam logic [7:0] OFS_LANE_POWER_DOWN_PIN      = 8'h01;
  localparam logic [7:0] OFS_POWER_DOWN_PIN_OVERRIDE  = 8'h02;
  localparam logic [7:0] OFS_PIN_OVERRIDE   = 8'h08;
  localparam logic [7:0] OFS_IDLE_RATE      = 8'h0e;
  localparam logic [7:0] OFS_EQUALIZER      = 8'h0f;
  localparam logic [7:0] OFS_OUTPUT_SWING   = 8'h10;
  localparam logic [7:0] OFS_STATUS_ROUTE   = 8'h4c;
  localparam int BIT_SOFT_RESET   = 0;
  localparam int BIT_RESET_GUARD  = 1;
  localparam int BIT_POWER_DOWN_PIN_OVR     = 0;
  localparam int BIT_RATE_OVR     = 2;
  localparam int BIT_IDLE_OVR     = 4;
  localparam int BIT_RATE_SEL     = 0;
  localparam int BIT_RATE_AUTO    = 1;
  localparam int BIT_IDLE_SEL     = 4;
  localparam int BIT_IDLE_AUTO    = 5;
  localparam int BIT_EQ_ENABLE    = 5;
  localparam logic [7:0] MASK_SOFT_RESET  = 8'h03;
  localparam logic [7:0] MASK_POWER_DOWN_PIN_OVR    = 8'h01;
  localparam logic [7:0] MASK_PIN_OVR     = 8'h14;
  localparam logic [7:0] MASK_IDLE_RATE   = 8'h33;
  localparam logic [7:0] MASK_EQUALIZER   = 8'h3f;
  localparam logic [7:0] MASK_SWING       = 8'h7f;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_EQUALIZER    = 8'h20;
  localparam logic [7:0] RST_SWING        = 8'h03;
  localparam logic [7:0] ROUTE_RATE_VALUE = 8'hc0;
  localparam logic [6:0] DEVICE_ADDR_BASE = 7'h50;
  localparam logic [7:0] READ_IDLE_VALUE  = 8'hff;
endpackage

// ### rtl/lcc_sync3.sv
// three-stage synchroniser for a vector of pin inputs; change accepted when stages agree
`timescale 1ns/10ps
`default_nettype none
module lcc_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } lcc_sync_t;
  lcc_sync_t st;
  lcc_sync_t next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.lvl[i] = st.s3[i];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign level = st.lvl;
endmodule
`default_nettype wire

// ### rtl/lcc_config_regs.sv
// serial-bus register bank controlling lane power, idle, rate, equalizer and swing
// Contract
// - soft reset bit restores defaults unless guarded
// - guard bit blocks soft reset requests
// - per-lane power-down bits, a-side high nibble
// - override bit ignores external power-down pin
// - override bit blocks external idle pin
// - override bit blocks external rate pin
// - idle auto bit, else forced idle
// - forced idle: zero mutes, one keeps on
// - rate auto bit, else forced rate
// - forced rate: zero low, one high
// - equalizer field: enable, gain stage, boost
// - equalizer defaults to enabled, gain stage and boost zero
// - output swing defaults to setting 3
// - status pin high for high rate
// - address, register, data bytes each acknowledged
`timescale 1ns/10ps
`default_nettype none
module lcc_config_regs
  import lcc_pkg::*;
#(
  parameter logic [3:0] ADDR_STRAP_DEFAULT = 4'h0
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       serial_config_enable,
  input  wire logic [3:0] addr_pins,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n,
  input  wire logic       power_down_pin,
  input  wire logic       idle_pin,
  input  wire logic       rate_pin,
  input  wire logic [3:0] lane_rate_detect,
  input  wire logic [3:0] lane_idle_detect,
  output var  logic [7:0] lane_power_off,
  output var  logic       lane0_muted,
  output var  logic       lane0_high_rate,
  output var  logic       lane0_eq_enable,
  output var  logic [1:0] lane0_gain_stage_field,
  output var  logic [2:0] lane0_boost_level_field,
  output var  logic [6:0] lane0_output_swing,
  output var  logic [1:0] rate_status_pin
);
  import lcc_pkg::*;

  typedef enum logic [2:0] {
    LCC_IDLE  = 3'b000,
    LCC_ADDR  = 3'b001,
    LCC_ACK   = 3'b010,
    LCC_RECV  = 3'b011,
    LCC_SEND  = 3'b100,
    LCC_MACK  = 3'b101,
    LCC_SKIP  = 3'b110
  } lcc_phase_t;

  typedef struct packed {
    lcc_phase_t phase;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [1:0] byte_no;
    logic       is_read;
    logic [7:0] reg_ptr;
    logic       sda_out;
    logic       sda_oe_n;
    logic [7:0] soft_reset_control;
    logic [7:0] lane_power_down;
    logic [7:0] power_down_override;
    logic [7:0] pin_control_override;
    logic [7:0] lane0_idle_rate_select;
    logic [7:0] lane0_equalizer;
    logic [7:0] lane0_output_swing;
    logic [7:0] status_route;
    logic [7:0] pwr;
    logic       muted;
    logic       high_rate;
    logic [1:0] rate_pin_out;
  } lcc_state_t;

  lcc_state_t st;
  lcc_state_t next_st;
  logic [2:0] pin_lvl;
  logic       scl_s;
  logic       sda_s;
  logic       cfg_en_s;
  logic [3:0] addr_s;

  // enable and address straps are pins too, so they share the filter
  lcc_sync3 #(.WIDTH(10)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .pin_in  ({scl_in, sda_in, serial_config_enable, addr_pins, power_down_pin, idle_pin,
               rate_pin}),
    .level   ({scl_s, sda_s, cfg_en_s, addr_s, pin_lvl})
  );

  function automatic logic [7:0] read_reg(input lcc_state_t s, input logic [7:0] a);
    case (a)
      OFS_SOFT_RESET:    read_reg = s.soft_reset_control;
      OFS_LANE_POWER_DOWN_PIN:     read_reg = s.lane_power_down;
      OFS_POWER_DOWN_PIN_OVERRIDE: read_reg = s.power_down_override;
      OFS_PIN_OVERRIDE:  read_reg = s.pin_control_override;
      OFS_IDLE_RATE:     read_reg = s.lane0_idle_rate_select;
      OFS_EQUALIZER:     read_reg = s.lane0_equalizer;
      OFS_OUTPUT_SWING:  read_reg = s.lane0_output_swing;
      OFS_STATUS_ROUTE:  read_reg = s.status_route;
      default:           read_reg = RST_ZERO;
    endcase
  endfunction

  function automatic lcc_state_t defaults(input lcc_state_t s);
    lcc_state_t d;
    d = s;
    d.soft_reset_control     = RST_ZERO;
    d.lane_power_down        = RST_ZERO;
    d.power_down_override    = RST_ZERO;
    d.pin_control_override   = RST_ZERO;
    d.lane0_idle_rate_select = RST_ZERO;
    d.lane0_equalizer        = RST_EQUALIZER;
    d.lane0_output_swing     = RST_SWING;
    d.status_route           = RST_ZERO;
    defaults = d;
  endfunction

  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic addr_hit;
  logic power_down_pin_eff;
  logic idle_ctl;
  logic rate_ctl;

  always_comb begin
    start_cond = st.scl_d && scl_s && st.sda_d && !sda_s;
    stop_cond  = st.scl_d && scl_s && !st.sda_d && sda_s;
    scl_rise   = !st.scl_d && scl_s;
    scl_fall   = st.scl_d && !scl_s;
    addr_hit   = st.shift[7:1] == (DEVICE_ADDR_BASE | {3'h0, addr_s});
    next_st = st;
    next_st.scl_d = scl_s;
    next_st.sda_d = sda_s;
    // serial slave, active only in serial configuration mode
    if (!cfg_en_s || stop_cond) begin
      next_st.phase    = LCC_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else if (start_cond) begin
      next_st.phase   = LCC_ADDR;
      next_st.bitcnt  = 4'h0;
      next_st.byte_no = 2'h0;
      next_st.sda_oe_n = 1'b1;
    end else begin
      case (st.phase)
        LCC_ADDR, LCC_RECV: begin
          if (scl_rise) begin
            next_st.shift  = {st.shift[6:0], sda_s};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end else if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            if (st.phase == LCC_ADDR) begin
              if (addr_hit) begin
                next_st.phase    = LCC_ACK;
                next_st.sda_out  = 1'b0;
                next_st.sda_oe_n = 1'b0;
                next_st.is_read  = st.shift[0];
                next_st.byte_no  = 2'h1;
              end else begin
                next_st.phase = LCC_SKIP;
              end
            end else begin
              next_st.phase    = LCC_ACK;
              next_st.sda_out  = 1'b0;
              next_st.sda_oe_n = 1'b0;
              if (st.byte_no == 2'h1) begin
                // register byte taken; the next byte is data
                next_st.reg_ptr = st.shift;
                next_st.byte_no = 2'h2;
              end else begin
                // value takes effect at data acknowledge
                case (st.reg_ptr)
                  OFS_SOFT_RESET: begin
                    next_st.soft_reset_control = st.shift & MASK_SOFT_RESET;
                    if (st.shift[BIT_SOFT_RESET] && !st.shift[BIT_RESET_GUARD]
                        && !st.soft_reset_control[BIT_RESET_GUARD]) begin
                      next_st = defaults(next_st);
                    end
                  end
                  OFS_LANE_POWER_DOWN_PIN:     next_st.lane_power_down = st.shift;
                  OFS_POWER_DOWN_PIN_OVERRIDE: next_st.power_down_override = st.shift & MASK_POWER_DOWN_PIN_OVR;
                  OFS_PIN_OVERRIDE:  next_st.pin_control_override = st.shift & MASK_PIN_OVR;
                  OFS_IDLE_RATE:     next_st.lane0_idle_rate_select = st.shift & MASK_IDLE_RATE;
                  OFS_EQUALIZER:     next_st.lane0_equalizer = st.shift & MASK_EQUALIZER;
                  OFS_OUTPUT_SWING:  next_st.lane0_output_swing = st.shift & MASK_SWING;
                  OFS_STATUS_ROUTE:  next_st.status_route = st.shift;
                  default:           next_st.reg_ptr = st.reg_ptr;
                endcase
              end
            end
          end
        end
        LCC_ACK: begin
          if (scl_fall) begin
            if (st.is_read) begin
              next_st.phase    = LCC_SEND;
              next_st.shift    = read_reg(st, st.reg_ptr);
              next_st.sda_out  = read_reg(st, st.reg_ptr) >> 7 != 8'h0;
              next_st.sda_oe_n = 1'b0;
              next_st.bitcnt   = 4'h0;
            end else begin
              next_st.phase    = LCC_RECV;
              next_st.sda_oe_n = 1'b1;
            end
          end
        end
        LCC_SEND: begin
          if (scl_fall) begin
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
              next_st.phase    = LCC_MACK;
              next_st.sda_oe_n = 1'b1;
            end else begin
              next_st.shift   = {st.shift[6:0], 1'b0};
              next_st.sda_out = st.shift[6];
            end
          end
        end
        LCC_MACK: begin
          if (scl_rise) begin
            next_st.phase = LCC_SKIP;
          end
        end
        LCC_IDLE, LCC_SKIP: begin
          next_st.sda_oe_n = 1'b1;
        end
        default: begin
          next_st.phase    = LCC_IDLE;
          next_st.sda_oe_n = 1'b1;
        end
      endcase
    end
    power_down_pin_eff = pin_lvl[2] && !st.power_down_override[BIT_POWER_DOWN_PIN_OVR];
    // per-lane power bits, a-side in bits 7:4
    next_st.pwr = st.lane_power_down | {8{power_down_pin_eff}};
    idle_ctl = st.lane0_idle_rate_select[BIT_IDLE_AUTO] ? lane_idle_detect[0]
             : !st.lane0_idle_rate_select[BIT_IDLE_SEL];
    next_st.muted = st.pin_control_override[BIT_IDLE_OVR] ? idle_ctl : pin_lvl[1];
    rate_ctl = st.lane0_idle_rate_select[BIT_RATE_AUTO] ? lane_rate_detect[0]
             : st.lane0_idle_rate_select[BIT_RATE_SEL];
    next_st.high_rate = st.pin_control_override[BIT_RATE_OVR] ? rate_ctl : pin_lvl[0];
    if (st.status_route == ROUTE_RATE_VALUE) begin
      next_st.rate_pin_out = {lane_rate_detect[1] | lane_rate_detect[3],
                              lane_rate_detect[0] | lane_rate_detect[2]};
    end else begin
      next_st.rate_pin_out = 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= defaults('0);
      st.sda_oe_n <= 1'b1;
      st.sda_out  <= 1'b1;
      // match the cleared synchroniser so no false edge follows reset
      st.scl_d    <= 1'b0;
      st.sda_d    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out                 = st.sda_out;
  assign sda_oe_n                = st.sda_oe_n;
  assign lane_power_off          = st.pwr;
  assign lane0_muted             = st.muted;
  assign lane0_high_rate         = st.high_rate;
  assign lane0_eq_enable         = st.lane0_equalizer[BIT_EQ_ENABLE];
  assign lane0_gain_stage_field  = st.lane0_equalizer[4:3];
  assign lane0_boost_level_field = st.lane0_equalizer[2:0];
  // swing field, reserved top bit excluded
  assign lane0_output_swing      = st.lane0_output_swing[6:0];
  assign rate_status_pin         = st.rate_pin_out;

  a_lane_power_map: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 ($past(st.lane_power_down) & ~st.pwr) == 8'h0) else $error("lane power mismatch");
  a_power_down_pin_override: assert property (@(posedge clock) disable iff (sys_rst)
    st.power_down_override[0] && st.lane_power_down == 8'h0 |=> st.pwr == 8'h0)
    else $error("power pin not ignored");
  // idle pin governs while not overridden
  a_idle_pin_ctl: assert property (@(posedge clock) disable iff (sys_rst)
    !st.pin_control_override[BIT_IDLE_OVR] |=> st.muted == $past(pin_lvl[1]))
    else $error("idle pin lost control");
  // forced mute when the idle pin is overridden
  a_forced_mute: assert property (@(posedge clock) disable iff (sys_rst)
    st.pin_control_override[BIT_IDLE_OVR] && st.lane0_idle_rate_select[5:4] == 2'b00
    |=> st.muted) else $error("forced mute lost");
  a_forced_rate: assert property (@(posedge clock) disable iff (sys_rst)
    st.pin_control_override[2] && st.lane0_idle_rate_select[1:0] == 2'b01 |=> st.high_rate)
    else $error("forced rate lost");
  a_eq_default: assert property (@(posedge clock)
    $past(sys_rst) |-> st.lane0_equalizer == 8'h20) else $error("eq default wrong");
  a_swing_default: assert property (@(posedge clock)
    $past(sys_rst) |-> lane0_output_swing == 7'h03) else $error("swing default wrong");
  // stored guard keeps other registers through a reset request
  a_guard_blocks: assert property (@(posedge clock) disable iff (sys_rst)
    st.phase == LCC_RECV && st.byte_no == 2'h2 && st.reg_ptr == OFS_SOFT_RESET
    && st.soft_reset_control[BIT_RESET_GUARD] |=> $stable(st.lane0_output_swing))
    else $error("guard failed");
  a_rate_status: assert property (@(posedge clock) disable iff (sys_rst)
    st.status_route != 8'hc0 |=> rate_status_pin == 2'h0) else $error("status leaked");
  a_ack_low: assert property (@(posedge clock) disable iff (sys_rst)
    st.phase == LCC_ACK |-> !st.sda_oe_n && !st.sda_out) else $error("ack not low");
  c_write_seen: cover property (@(posedge clock) st.phase == LCC_RECV && st.byte_no == 2'h2);
  c_read_seen: cover property (@(posedge clock) st.phase == LCC_SEND);
  c_route_on: cover property (@(posedge clock) st.status_route == 8'hc0);
endmodule
`default_nettype wire

// ### dv/lcc_smb_host.sv
// serial bus host model issuing single-byte register writes and reads
`timescale 1ns/10ps
`default_nettype none
module lcc_smb_host #(
  parameter int QTR = 8
) (
  input  wire logic clock,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  // pace 2 halves the bit rate for the slow host case
  int pace = 1;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wq(input int n);
    repeat (n * QTR * pace) @(posedge clock);
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    wq(1);
    scl <= 1'b1;
    wq(1);
    sda_low <= 1'b1;
    wq(1);
    scl <= 1'b0;
    wq(1);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    wq(1);
    scl <= 1'b1;
    wq(1);
    sda_low <= 1'b0;
    wq(1);
  endtask
  task automatic put_bit(input logic b);
    sda_low <= ~b;
    wq(1);
    scl <= 1'b1;
    wq(2);
    scl <= 1'b0;
    wq(1);
  endtask
  // released line reads the pull-up level
  task automatic get_bit(output logic b);
    sda_low <= 1'b0;
    wq(1);
    scl <= 1'b1;
    wq(1);
    b = sda_line;
    wq(1);
    scl <= 1'b0;
    wq(1);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nack);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                           output logic ok);
    logic n1, n2, n3;
    n2 = 1'b0;
    n3 = 1'b0;
    start_cond();
    send_byte({dev, 1'b0}, n1);
    if (!n1) begin
      send_byte(ra, n2);
      send_byte(d, n3);
    end
    stop_cond();
    ok = !n1 && !n2 && !n3;
  endtask
  // address, register, repeated start, read, nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d,
                          output logic ok);
    logic n1, n2, n3, b;
    n2 = 1'b0;
    n3 = 1'b0;
    d = 8'h00;
    start_cond();
    send_byte({dev, 1'b0}, n1);
    if (!n1) begin
      send_byte(ra, n2);
      start_cond();
      send_byte({dev, 1'b1}, n3);
      for (int i = 7; i >= 0; i--) begin
        get_bit(b);
        d[i] = b;
      end
      put_bit(1'b1);
    end
    stop_cond();
    ok = !n1 && !n2 && !n3;
  endtask
endmodule
`default_nettype wire

// ### dv/lane_conditioning_config_regs_tb_top.sv
// testbench for the lane conditioning register bank
`timescale 1ns/10ps
`default_nettype none
module lane_conditioning_config_regs_tb_top;
  import lcc_pkg::*;
  logic       clock, sys_rst, serial_config_enable, scl, host_sda_low, sda_out, sda_oe_n;
  logic       power_down_pin, idle_pin, rate_pin, lane0_muted, lane0_high_rate;
  logic       lane0_eq_enable, ok;
  logic [3:0] addr_pins, lane_rate_detect, lane_idle_detect, k;
  logic [7:0] lane_power_off, rd, r0e;
  logic [1:0] lane0_gain_stage_field, rate_status_pin;
  logic [2:0] lane0_boost_level_field;
  logic [6:0] lane0_output_swing, dev;
  wire        sda_line;
  int         n_fail = 0;
  int         n_compared = 0;
  localparam logic [7:0] OFS [7] = '{OFS_SOFT_RESET, OFS_LANE_POWER_DOWN_PIN, OFS_POWER_DOWN_PIN_OVERRIDE,
    OFS_PIN_OVERRIDE, OFS_IDLE_RATE, OFS_EQUALIZER, OFS_OUTPUT_SWING};
  localparam logic [7:0] DEF [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h03};
  localparam logic [7:0] WRV [7] = '{8'h00, 8'ha5, 8'h01, 8'h14, 8'h33, 8'h3d, 8'h0f};
  localparam logic [7:0] EQV [8] = '{8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3b, 8'h3d};
  localparam logic [7:0] SWV [3] = '{8'h03, 8'h07, 8'h0f};
  // open-drain line with pull-up
  assign sda_line = ~(host_sda_low | (~sda_oe_n & ~sda_out));
  lcc_config_regs lcc_config_regs_inst (
    .clock(clock), .sys_rst(sys_rst), .serial_config_enable(serial_config_enable),
    .addr_pins(addr_pins), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .power_down_pin(power_down_pin), .idle_pin(idle_pin),
    .rate_pin(rate_pin), .lane_rate_detect(lane_rate_detect),
    .lane_idle_detect(lane_idle_detect), .lane_power_off(lane_power_off),
    .lane0_muted(lane0_muted), .lane0_high_rate(lane0_high_rate),
    .lane0_eq_enable(lane0_eq_enable), .lane0_gain_stage_field(lane0_gain_stage_field),
    .lane0_boost_level_field(lane0_boost_level_field),
    .lane0_output_swing(lane0_output_swing), .rate_status_pin(rate_status_pin));
  lcc_smb_host lcc_smb_host_inst (
    .clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(host_sda_low));
  always #5 clock = ~clock;
  task automatic summarize();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    lcc_smb_host_inst.write_reg(dev, ra, d, ok);
    chk_bit(ok, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
    lcc_smb_host_inst.read_reg(dev, ra, rd, ok);
    chk_bit(ok, 1'b1);
    chk_val(rd, exp);
  endtask
  task automatic check_defaults();
    for (int i = 0; i < 7; i++) rd_chk(OFS[i], DEF[i]);
    chk_val({2'b00, lane0_eq_enable, lane0_gain_stage_field, lane0_boost_level_field}, 8'h20);
    chk_val({1'b0, lane0_output_swing}, RST_SWING);
  endtask
  task automatic lane_pass(input logic ovr, input logic [7:0] r, input logic d);
    idle_pin <= d;
    rate_pin <= d;
    lane_idle_detect <= {4{~d}};
    lane_rate_detect <= {4{~d}};
    repeat (12) @(posedge clock);
    chk_bit(lane0_muted, ovr ? (r[5] ? ~d : ~r[4]) : d);
    chk_bit(lane0_high_rate, ovr ? (r[1] ? ~d : r[0]) : d);
  endtask
  initial begin
    // about 78k cycles of bus traffic are expected; stay under 95k
    #950000;
    n_fail++;
    summarize();
  end
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    serial_config_enable = 1'b1;
    {addr_pins, power_down_pin, idle_pin, rate_pin} = '0;
    {lane_rate_detect, lane_idle_detect} = '0;
    dev = DEVICE_ADDR_BASE;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    check_defaults();
    rd_chk(8'h05, 8'h00);
    $display("test defaults done");
    for (int i = 1; i < 7; i++) wr(OFS[i], WRV[i]);
    for (int i = 1; i < 7; i++) rd_chk(OFS[i], WRV[i]);
    chk_val(lane_power_off, 8'ha5);
    chk_val({2'b00, lane0_eq_enable, lane0_gain_stage_field, lane0_boost_level_field}, 8'h3d);
    $display("test access done");
    wr(OFS_SOFT_RESET, 8'h03);
    rd_chk(OFS_OUTPUT_SWING, 8'h0f);
    wr(OFS_SOFT_RESET, 8'h01);
    rd_chk(OFS_OUTPUT_SWING, 8'h0f);
    wr(OFS_SOFT_RESET, 8'h00);
    wr(OFS_SOFT_RESET, 8'h01);
    chk_val(lane_power_off, 8'h00);
    check_defaults();
    $display("test soft reset done");
    foreach (EQV[i]) begin
      wr(OFS_EQUALIZER, EQV[i]);
      chk_val({2'b00, lane0_eq_enable, lane0_gain_stage_field, lane0_boost_level_field}, EQV[i]);
    end
    foreach (SWV[i]) begin
      wr(OFS_OUTPUT_SWING, SWV[i]);
      chk_val({1'b0, lane0_output_swing}, SWV[i]);
    end
    $display("test equalizer and swing done");
    power_down_pin <= 1'b1;
    repeat (12) @(posedge clock);
    chk_val(lane_power_off, 8'hff);
    wr(OFS_POWER_DOWN_PIN_OVERRIDE, 8'h01);
    chk_val(lane_power_off, 8'h00);
    wr(OFS_LANE_POWER_DOWN_PIN, 8'h5a);
    chk_val(lane_power_off, 8'h5a);
    power_down_pin <= 1'b0;
    $display("test power down done");
    for (int j = 0; j < 20; j++) begin
      if (j == 0 || j == 16) wr(OFS_PIN_OVERRIDE, (j == 0) ? 8'h14 : 8'h00);
      k = 4'(j);
      r0e = {2'b00, k[3:2], 2'b00, k[1:0]};
      wr(OFS_IDLE_RATE, r0e);
      for (int d = 0; d < 2; d++) lane_pass(j < 16, r0e, d[0]);
    end
    $display("test idle and rate done");
    wr(OFS_STATUS_ROUTE, ROUTE_RATE_VALUE);
    for (int v = 0; v < 16; v++) begin
      lane_rate_detect <= 4'(v);
      repeat (4) @(posedge clock);
      chk_val({6'h00, rate_status_pin}, {6'h00, v[1] | v[3], v[0] | v[2]});
    end
    wr(OFS_STATUS_ROUTE, 8'h00);
    chk_val({6'h00, rate_status_pin}, 8'h00);
    $display("test rate status done");
    lcc_smb_host_inst.pace = 2;
    lcc_smb_host_inst.write_reg(DEVICE_ADDR_BASE | 7'h01, OFS_OUTPUT_SWING, 8'h3f, ok);
    chk_bit(ok, 1'b0);
    serial_config_enable <= 1'b0;
    repeat (8) @(posedge clock);
    lcc_smb_host_inst.write_reg(dev, OFS_OUTPUT_SWING, 8'h3f, ok);
    chk_bit(ok, 1'b0);
    chk_val({1'b0, lane0_output_swing}, 8'h0f);
    serial_config_enable <= 1'b1;
    addr_pins <= 4'h9;
    dev = DEVICE_ADDR_BASE | 7'h09;
    repeat (8) @(posedge clock);
    wr(OFS_OUTPUT_SWING, 8'h1f);
    chk_val({1'b0, lane0_output_swing}, 8'h1f);
    rd_chk(OFS_OUTPUT_SWING, 8'h1f);
    $display("test refusals done");
    summarize();
  end
endmodule
`default_nettype wire
